// ==== rtl/async_serial_transmitter.v ====
// asynchronous transmit path with avalon-mm register access
//
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "tx_uart_defines.vh"

module async_serial_transmitter (
  input  wire        core_clk_in,
  input  wire        srst_in,
  input  wire [4:0]  address_in,
  input  wire        read_in,
  input  wire        write_in,
  input  wire [31:0] writedata_in,
  input  wire [3:0]  byteenable_in,
  input  wire        sleep_in,
  output wire [31:0] readdata_out,
  output wire        waitrequest_out,
  output wire        tx_pin_out,
  output wire        tx_pin_oe_out,
  output wire        tx_irq_out
);

  localparam ST_IDLE  = 5'h01;
  localparam ST_WAIT  = 5'h02;
  localparam ST_START = 5'h04;
  localparam ST_DATA  = 5'h08;
  localparam ST_STOP  = 5'h10;

  // configuration
  reg  [7:0]  baud_divisor_ff;
  reg         ninth_bit_value_ff;
  reg         high_speed_baud_select_ff;
  reg         sync_select_ff;
  reg         transmit_enable_ff;
  reg         nine_bit_transmit_select_ff;
  reg         serial_port_enable_ff;
  reg         tx_buffer_empty_irq_enable_ff;

  // bus slave
  reg         wait_ff;
  reg  [31:0] rdata_ff;
  reg  [31:0] nxt_rdata;

  // transmitter
  reg  [4:0]  state_ff;
  reg  [4:0]  nxt_state;
  reg  [8:0]  shift_ff;
  reg  [8:0]  nxt_shift;
  reg  [3:0]  bit_cnt_ff;
  reg  [3:0]  nxt_bit_cnt;
  reg  [3:0]  frame_bits_ff;
  reg  [3:0]  nxt_frame_bits;
  reg  [7:0]  hold_data_ff;
  reg  [7:0]  nxt_hold_data;
  reg         hold_full_ff;
  reg         nxt_hold_full;
  reg         shift_idle_flag_ff;
  reg         nxt_shift_idle_flag;
  reg         line_ff;
  reg         nxt_line;
  reg         oe_ff;
  reg         irq_ff;

  wire        bus_req;
  wire        bus_done;
  wire [2:0]  reg_idx;
  wire        wr_low;
  wire        hold_write;
  wire        tx_active;
  wire        tx_buffer_empty_flag;
  wire        bit_tick;
  wire [6:0]  prescale;

  assign bus_req         = read_in || write_in;
  assign bus_done        = bus_req && !wait_ff;
  assign reg_idx         = address_in[4:2];
  assign wr_low          = write_in && !wait_ff && byteenable_in[0];
  assign hold_write      = wr_low && (reg_idx == `IDX_HOLD_BUFFER) && serial_port_enable_ff;
  assign readdata_out    = rdata_ff;
  assign waitrequest_out = wait_ff;
  assign tx_pin_out      = line_ff;
  assign tx_pin_oe_out   = oe_ff;
  assign tx_irq_out      = irq_ff;

  // asynchronous path only runs with the synchronous select cleared
  assign tx_active = serial_port_enable_ff && transmit_enable_ff && !sync_select_ff;

  assign tx_buffer_empty_flag = serial_port_enable_ff && transmit_enable_ff && !hold_full_ff;

  assign prescale = sync_select_ff ? `PRESCALE_SYNC :
                    (high_speed_baud_select_ff ? `PRESCALE_HS : `PRESCALE_LS);

  // ninth bit is fixed at load time, so a late write to it misses the frame
  function [8:0] frame_word;
    input [7:0] data;
    input       nine_sel;
    input       ninth;
    begin
      frame_word = {nine_sel ? ninth : 1'b1, data};
    end
  endfunction

  // one divider paces the transmit path of the port
  baud_tick_gen #(
    .DIV_W (8),
    .PRE_W (7)
  ) u_baud (
    .core_clk_in  (core_clk_in),
    .srst_in      (srst_in),
    .clear_in     (!serial_port_enable_ff),
    .run_in       (!sleep_in),
    .divisor_in   (baud_divisor_ff),
    .prescale_in  (prescale),
    .bit_tick_out (bit_tick)
  );

  // avalon handshake: one wait cycle, then the answer
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h00000000;
    end
    else
    begin
      wait_ff <= !(bus_req && wait_ff);
      if (bus_req && wait_ff)
      begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  always @*
  begin
    nxt_rdata = 32'h00000000;
    case (reg_idx)
      `IDX_TX_CONTROL:
      begin
        nxt_rdata[`TXC_NINTH_VAL] = ninth_bit_value_ff;
        nxt_rdata[`TXC_IDLE_FLAG] = shift_idle_flag_ff;
        nxt_rdata[`TXC_HS_SEL]    = high_speed_baud_select_ff;
        nxt_rdata[`TXC_SYNC_SEL]  = sync_select_ff;
        nxt_rdata[`TXC_TX_ENABLE] = transmit_enable_ff;
        nxt_rdata[`TXC_NINE_SEL]  = nine_bit_transmit_select_ff;
      end
      `IDX_RX_CONTROL:
      begin
        nxt_rdata[`RXC_PORT_ENABLE] = serial_port_enable_ff;
      end
      `IDX_BAUD_DIVISOR:
      begin
        nxt_rdata[7:0] = baud_divisor_ff;
      end
      `IDX_IRQ_CONTROL:
      begin
        nxt_rdata[`IRQ_ENABLE_BIT] = tx_buffer_empty_irq_enable_ff;
        nxt_rdata[`IRQ_EMPTY_BIT]  = tx_buffer_empty_flag;
      end
      default:
      begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  // configuration stays writable while the port is disabled
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      baud_divisor_ff               <= `RST_BYTE;
      ninth_bit_value_ff            <= `RST_BIT;
      high_speed_baud_select_ff     <= `RST_BIT;
      sync_select_ff                <= `RST_BIT;
      transmit_enable_ff            <= `RST_BIT;
      nine_bit_transmit_select_ff   <= `RST_BIT;
      serial_port_enable_ff         <= `RST_BIT;
      tx_buffer_empty_irq_enable_ff <= `RST_BIT;
    end
    else if (wr_low)
    begin
      case (reg_idx)
        `IDX_TX_CONTROL:
        begin
          ninth_bit_value_ff          <= writedata_in[`TXC_NINTH_VAL];
          high_speed_baud_select_ff   <= writedata_in[`TXC_HS_SEL];
          sync_select_ff              <= writedata_in[`TXC_SYNC_SEL];
          transmit_enable_ff          <= writedata_in[`TXC_TX_ENABLE];
          nine_bit_transmit_select_ff <= writedata_in[`TXC_NINE_SEL];
        end
        `IDX_RX_CONTROL:
        begin
          serial_port_enable_ff <= writedata_in[`RXC_PORT_ENABLE];
        end
        `IDX_BAUD_DIVISOR:
        begin
          baud_divisor_ff <= writedata_in[7:0];
        end
        `IDX_IRQ_CONTROL:
        begin
          tx_buffer_empty_irq_enable_ff <= writedata_in[`IRQ_ENABLE_BIT];
        end
        default:
        begin
          baud_divisor_ff <= baud_divisor_ff;
        end
      endcase
    end
  end

  // transmit state machine
  always @*
  begin
    nxt_state           = state_ff;
    nxt_shift           = shift_ff;
    nxt_bit_cnt         = bit_cnt_ff;
    nxt_frame_bits      = frame_bits_ff;
    nxt_hold_data       = hold_data_ff;
    nxt_hold_full       = hold_full_ff;
    nxt_shift_idle_flag = shift_idle_flag_ff;
    nxt_line            = line_ff;
    if (!serial_port_enable_ff)
    begin
      nxt_state           = ST_IDLE;
      nxt_hold_full       = 1'b0;
      nxt_shift_idle_flag = 1'b1;
      nxt_line            = 1'b1;
      nxt_bit_cnt         = 4'h0;
    end
    else
    begin
      // a load arriving with a transfer out keeps the new byte
      if (hold_write)
      begin
        nxt_hold_full = 1'b1;
        nxt_hold_data = writedata_in[7:0];
      end
      if (!tx_active)
      begin
        nxt_state           = ST_IDLE;
        nxt_shift_idle_flag = 1'b1;
        nxt_line            = 1'b1;
        nxt_bit_cnt         = 4'h0;
      end
      else if (!sleep_in)
      begin
        case (state_ff)
          ST_IDLE:
          begin
            nxt_line = 1'b1;
            if (hold_full_ff)
            begin
              nxt_shift = frame_word(hold_data_ff, nine_bit_transmit_select_ff,
                                     ninth_bit_value_ff);
              nxt_frame_bits      = nine_bit_transmit_select_ff ? `BITS_NINE : `BITS_EIGHT;
              nxt_hold_full       = hold_write;
              nxt_shift_idle_flag = 1'b0;
              nxt_state           = ST_WAIT;
            end
          end
          ST_WAIT:
          begin
            if (bit_tick)
            begin
              nxt_line  = 1'b0;
              nxt_state = ST_START;
            end
          end
          ST_START:
          begin
            if (bit_tick)
            begin
              nxt_line    = shift_ff[0];
              nxt_shift   = {1'b0, shift_ff[8:1]};
              nxt_bit_cnt = 4'h1;
              nxt_state   = ST_DATA;
            end
          end
          ST_DATA:
          begin
            if (bit_tick)
            begin
              if (bit_cnt_ff == frame_bits_ff)
              begin
                nxt_line  = 1'b1;
                nxt_state = ST_STOP;
              end
              else
              begin
                nxt_line    = shift_ff[0];
                nxt_shift   = {1'b0, shift_ff[8:1]};
                nxt_bit_cnt = bit_cnt_ff + 4'h1;
              end
            end
          end
          ST_STOP:
          begin
            if (bit_tick)
            begin
              if (hold_full_ff)
              begin
                nxt_shift = frame_word(hold_data_ff, nine_bit_transmit_select_ff,
                                       ninth_bit_value_ff);
                nxt_frame_bits = nine_bit_transmit_select_ff ? `BITS_NINE : `BITS_EIGHT;
                nxt_hold_full  = hold_write;
                nxt_line       = 1'b0;
                nxt_state      = ST_START;
              end
              else
              begin
                nxt_shift_idle_flag = 1'b1;
                nxt_state           = ST_IDLE;
              end
            end
          end
          default:
          begin
            nxt_state = ST_IDLE;
            nxt_line  = 1'b1;
          end
        endcase
      end
    end
  end

  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      state_ff           <= ST_IDLE;
      shift_ff           <= 9'h000;
      bit_cnt_ff         <= 4'h0;
      frame_bits_ff      <= `BITS_EIGHT;
      hold_data_ff       <= `RST_BYTE;
      hold_full_ff       <= 1'b0;
      shift_idle_flag_ff <= 1'b1;
      line_ff            <= 1'b1;
      oe_ff              <= 1'b0;
      irq_ff             <= 1'b0;
    end
    else
    begin
      state_ff           <= nxt_state;
      shift_ff           <= nxt_shift;
      bit_cnt_ff         <= nxt_bit_cnt;
      frame_bits_ff      <= nxt_frame_bits;
      hold_data_ff       <= nxt_hold_data;
      hold_full_ff       <= nxt_hold_full;
      shift_idle_flag_ff <= nxt_shift_idle_flag;
      line_ff            <= nxt_line;
      // drives regardless of the port direction bit; released on abort
      oe_ff  <= tx_active;
      irq_ff <= serial_port_enable_ff && transmit_enable_ff && !nxt_hold_full
                && tx_buffer_empty_irq_enable_ff;
    end
  end

endmodule // async_serial_transmitter

// ==== rtl/tx_uart_defines.vh ====
// register map, field positions and reset values of the serial transmitter
`ifndef TX_UART_DEFINES_VH
`define TX_UART_DEFINES_VH

// word index of each register (byte address = index * 4)
`define IDX_TX_CONTROL    3'h0
`define IDX_RX_CONTROL    3'h1
`define IDX_BAUD_DIVISOR  3'h2
`define IDX_HOLD_BUFFER   3'h3
`define IDX_IRQ_CONTROL   3'h4

// transmit_control_reg fields
`define TXC_NINTH_VAL     0
`define TXC_IDLE_FLAG     1
`define TXC_HS_SEL        2
`define TXC_SYNC_SEL      4
`define TXC_TX_ENABLE     5
`define TXC_NINE_SEL      6

// receive_control_reg fields
`define RXC_PORT_ENABLE   7

// irq control fields
`define IRQ_ENABLE_BIT    0
`define IRQ_EMPTY_BIT     1

// reset values
`define RST_BYTE          8'h00
`define RST_BIT           1'b0

// baud prescale multiples
`define PRESCALE_HS       7'h10
`define PRESCALE_LS       7'h40
`define PRESCALE_SYNC     7'h04

// frame lengths in data bits
`define BITS_EIGHT        4'h8
`define BITS_NINE         4'h9

`endif

// ==== rtl/baud_tick_gen.v ====
// baud divider: one-cycle tick every prescale * (divisor + 1) clocks
`timescale 1ns/1ps
module baud_tick_gen #(
  parameter DIV_W = 8,
  parameter PRE_W = 7
) (
  input  wire             core_clk_in,
  input  wire             srst_in,
  input  wire             clear_in,
  input  wire             run_in,
  input  wire [DIV_W-1:0] divisor_in,
  input  wire [PRE_W-1:0] prescale_in,
  output wire             bit_tick_out
);

  reg  [DIV_W-1:0] div_cnt_ff;
  reg  [PRE_W-1:0] pre_cnt_ff;
  reg              tick_ff;
  wire             div_end;
  wire             pre_end;

  assign div_end      = (div_cnt_ff == divisor_in);
  assign pre_end      = (pre_cnt_ff == prescale_in - {{(PRE_W-1){1'b0}}, 1'b1});
  assign bit_tick_out = tick_ff;

  // counts up so a divisor change takes effect without a stale reload
  always @(posedge core_clk_in)
  begin
    if (srst_in || clear_in)
    begin
      div_cnt_ff <= {DIV_W{1'b0}};
      pre_cnt_ff <= {PRE_W{1'b0}};
      tick_ff    <= 1'b0;
    end
    else if (run_in)
    begin
      tick_ff <= div_end && pre_end;
      if (div_end)
      begin
        div_cnt_ff <= {DIV_W{1'b0}};
        pre_cnt_ff <= pre_end ? {PRE_W{1'b0}} : pre_cnt_ff + {{(PRE_W-1){1'b0}}, 1'b1};
      end
      else
      begin
        div_cnt_ff <= div_cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1};
      end
    end
    else
    begin
      tick_ff <= 1'b0;
    end
  end

endmodule // baud_tick_gen

// ==== testbench/tx_uart_sva.sv ====
// port-level assertions for the serial transmitter
`timescale 1ns/1ps
`include "tx_uart_defines.vh"
module tx_uart_sva (
  input logic        core_clk_in,
  input logic        srst_in,
  input logic [4:0]  address_in,
  input logic        read_in,
  input logic        write_in,
  input logic [31:0] writedata_in,
  input logic [3:0]  byteenable_in,
  input logic        sleep_in,
  input logic [31:0] readdata_out,
  input logic        waitrequest_out,
  input logic        tx_pin_out,
  input logic        tx_pin_oe_out,
  input logic        tx_irq_out
);
  logic [7:0]  ctl_ff;
  logic [7:0]  div_ff;
  logic        pen_ff;
  logic        ien_ff;
  logic        pin_ff;
  logic        slept_ff;
  int          run_ff;
  wire         wr_ok  = write_in && !waitrequest_out && byteenable_in[0];
  wire         oe_ok  = pen_ff && ctl_ff[5] && !ctl_ff[4];
  wire         irq_ok = pen_ff && ctl_ff[5] && ien_ff;
  wire  [15:0] per    = (ctl_ff[2] ? 16'h0010 : 16'h0040) * ({8'h00, div_ff} + 16'h0001);
  // shadow of the configuration, so the rate is known without looking inside
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      ctl_ff <= 8'h00;
      div_ff <= 8'h00;
      pen_ff <= 1'b0;
      ien_ff <= 1'b0;
    end
    else if (wr_ok)
    begin
      case (address_in[4:2])
        `IDX_TX_CONTROL:   ctl_ff <= writedata_in[7:0];
        `IDX_RX_CONTROL:   pen_ff <= writedata_in[7];
        `IDX_BAUD_DIVISOR: div_ff <= writedata_in[7:0];
        `IDX_IRQ_CONTROL:  ien_ff <= writedata_in[0];
        default:           ;
      endcase
    end
  end
  // length of the current line level; a sleep inside it spoils the count
  always_ff @(posedge core_clk_in)
  begin
    pin_ff   <= srst_in || tx_pin_out;
    run_ff   <= (tx_pin_out != pin_ff) ? 1 : run_ff + 1;
    slept_ff <= !srst_in && (sleep_in || ((tx_pin_out != pin_ff) ? 1'b0 : slept_ff));
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  sequence req_s;   (read_in || write_in) && waitrequest_out; endsequence
  sequence oe_s;    oe_ok [*3]; endsequence
  sequence no_oe_s; !oe_ok [*3]; endsequence
  sequence no_irq_s; !irq_ok [*3]; endsequence
  sequence low_end_s; tx_pin_out && !pin_ff && tx_pin_oe_out && !slept_ff; endsequence
  bus_answer_a: assert property (req_s |=> !waitrequest_out)
    else $error("bus request not answered next cycle");
  answer_pulse_a: assert property (!waitrequest_out |=> waitrequest_out)
    else $error("waitrequest low longer than one cycle");
  upper_zero_a: assert property (read_in && !waitrequest_out |-> readdata_out[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  unmapped_read_a: assert property (read_in && !waitrequest_out && address_in[4:2] > 3'h4
    |-> readdata_out == 32'h00000000) else $error("unmapped word reads nonzero");
  idle_high_a: assert property (!tx_pin_oe_out |-> tx_pin_out)
    else $error("released line not high");
  pin_drive_a: assert property (oe_s |-> tx_pin_oe_out)
    else $error("line not driven while transmitter enabled");
  pin_release_a: assert property (no_oe_s |-> !tx_pin_oe_out)
    else $error("line driven while transmitter off or synchronous");
  irq_gate_a: assert property (no_irq_s |-> !tx_irq_out)
    else $error("interrupt request without its enables");
  bit_period_a: assert property (low_end_s |-> run_ff % per == 0)
    else $error("low run not a whole number of bit periods");
  frame_len_a: assert property (low_end_s |-> run_ff <= 10 * per)
    else $error("low run longer than a frame");
  sleep_freeze_a: assert property (sleep_in && $past(sleep_in) |-> $stable(tx_pin_out))
    else $error("line moved during sleep");
endmodule // tx_uart_sva
bind async_serial_transmitter tx_uart_sva u_sva (.core_clk_in(core_clk_in), .srst_in(srst_in),
  .address_in(address_in), .read_in(read_in), .write_in(write_in),
  .writedata_in(writedata_in), .byteenable_in(byteenable_in), .sleep_in(sleep_in),
  .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .tx_pin_out(tx_pin_out),
  .tx_pin_oe_out(tx_pin_oe_out), .tx_irq_out(tx_irq_out));

// ==== testbench/serial_rx_model.sv ====
// far-end receiver sampling the transmit line at bit centres
`timescale 1ns/1ps
module serial_rx_model (
  input  wire        core_clk_in,
  input  wire        line_in,
  input  wire        oe_in,
  input  wire        nine_in,
  input  wire [15:0] period_in,
  output reg         got_out,
  output reg  [9:0]  frame_out
);
  integer   i;
  reg [9:0] f;
  initial got_out = 1'b0;
  initial frame_out = 10'h000;
  always
  begin : rx
    @(posedge core_clk_in);
    got_out <= 1'b0;
    if (oe_in === 1'b1 && line_in === 1'b0)
    begin
      // centre sampling tolerates the one-cycle start detection delay
      repeat (period_in / 2) @(posedge core_clk_in);
      f = 10'h3FF;
      for (i = 0; i < (nine_in ? 10 : 9); i = i + 1)
      begin
        repeat (period_in) @(posedge core_clk_in);
        if (oe_in !== 1'b1)
          disable rx;
        f[i] = line_in;
      end
      got_out <= 1'b1;
      frame_out <= f;
    end
  end
endmodule // serial_rx_model

// ==== testbench/async_serial_transmitter_tb_top.sv ====
// self-checking bench for the serial transmitter
`timescale 1ns/1ps
`include "tx_uart_defines.vh"
module async_serial_transmitter_tb_top;
  logic        core_clk_in, srst_in, read_in, write_in, sleep_in, nine, rd_chk;
  logic [4:0]  address_in;
  logic [31:0] writedata_in, v;
  logic [3:0]  byteenable_in;
  logic [15:0] per;
  logic [7:0]  ctl, d;
  wire  [31:0] readdata_out;
  wire         waitrequest_out, tx_pin_out, tx_pin_oe_out, tx_irq_out, got;
  wire  [9:0]  frame;
  int          failures, n_compared, i;
  logic [31:0] exp_rd[$];
  logic [9:0]  exp_rx[$];
  async_serial_transmitter uut (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .byteenable_in(byteenable_in), .sleep_in(sleep_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .tx_pin_out(tx_pin_out),
    .tx_pin_oe_out(tx_pin_oe_out), .tx_irq_out(tx_irq_out));
  serial_rx_model far_rx (.core_clk_in(core_clk_in), .line_in(tx_pin_out),
    .oe_in(tx_pin_oe_out), .nine_in(nine), .period_in(per), .got_out(got), .frame_out(frame));
  initial
  begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("failures=%0d n_compared=%0d", failures, n_compared);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // waits for the answer however long it takes; only the watchdog ends a hang
  task ack;
    do
      @(posedge core_clk_in);
    while (waitrequest_out !== 1'b0);
  endtask
  task bus_wr(input logic [2:0] idx, input logic [7:0] dat, input logic [3:0] be = 4'hF);
    @(posedge core_clk_in);
    address_in <= {idx, 2'b00};
    writedata_in <= {24'h000000, dat};
    byteenable_in <= be;
    write_in <= 1'b1;
    ack();
    write_in <= 1'b0;
  endtask
  task bus_rd(input logic [2:0] idx, input logic [31:0] exp, input logic chk);
    @(posedge core_clk_in);
    if (chk)
      exp_rd.push_back(exp);
    rd_chk <= chk;
    address_in <= {idx, 2'b00};
    read_in <= 1'b1;
    ack();
    v = readdata_out;
    read_in <= 1'b0;
  endtask
  // ninth bit goes in before the data byte, as the load can pass straight through
  task send(input logic [7:0] dat, input logic b9);
    do
      bus_rd(`IDX_IRQ_CONTROL, 32'h0, 1'b0);
    while (v[`IRQ_EMPTY_BIT] !== 1'b1);
    bus_wr(`IDX_TX_CONTROL, ctl | {7'h00, b9});
    exp_rx.push_back(nine ? {1'b1, b9, dat} : {2'b11, dat});
    bus_wr(`IDX_HOLD_BUFFER, dat);
  endtask
  task drain;
    while (exp_rx.size() != 0)
      @(posedge core_clk_in);
    repeat (per) @(posedge core_clk_in);
  endtask
  always @(posedge core_clk_in)
    if (read_in === 1'b1 && waitrequest_out === 1'b0 && rd_chk === 1'b1)
      check(readdata_out, exp_rd.pop_front());
  always @(posedge core_clk_in)
    if (got === 1'b1)
      check({22'h0, frame}, {22'h0, exp_rx.pop_front()});
  initial
  begin
    repeat (60000) @(posedge core_clk_in);
    failures++;
    end_of_test();
  end
  initial
  begin
    {read_in, write_in, sleep_in, nine, rd_chk} = 5'h00;
    address_in = 5'h00;
    writedata_in = 32'h0;
    byteenable_in = 4'hF;
    per = 16'h0020;
    ctl = 8'h24;
    v = $urandom(32'h7285c38a);
    srst_in = 1'b1;
    repeat (12) @(posedge core_clk_in);
    srst_in <= 1'b0;
    for (i = 0; i < 8; i++)
      bus_rd(i[2:0], (i == 0) ? 32'h2 : 32'h0, 1'b1);
    // preconfigure while the port is off; the data load must be refused
    bus_wr(`IDX_BAUD_DIVISOR, 8'h01);
    bus_wr(`IDX_HOLD_BUFFER, 8'hA5);
    bus_wr(`IDX_BAUD_DIVISOR, 8'h7E, 4'hE);
    bus_rd(`IDX_BAUD_DIVISOR, 32'h1, 1'b1);
    bus_wr(`IDX_TX_CONTROL, ctl);
    bus_rd(`IDX_IRQ_CONTROL, 32'h0, 1'b1);
    bus_wr(`IDX_RX_CONTROL, 8'h80);
    bus_wr(`IDX_IRQ_CONTROL, 8'h01);
    bus_rd(`IDX_IRQ_CONTROL, 32'h3, 1'b1);
    repeat (3) @(posedge core_clk_in);
    check({31'h0, tx_irq_out}, 32'h1);
    send($urandom, 1'b0);
    bus_rd(`IDX_TX_CONTROL, 32'h24, 1'b1);
    bus_rd(`IDX_IRQ_CONTROL, 32'h3, 1'b1);
    for (i = 0; i < 3; i++)
      send($urandom, 1'b0);
    drain();
    bus_rd(`IDX_TX_CONTROL, 32'h26, 1'b1);
    nine = 1'b1;
    ctl = 8'h64;
    for (i = 0; i < 4; i++)
      send($urandom, i[0]);
    drain();
    nine = 1'b0;
    ctl = 8'h20;
    per = 16'h0040;
    bus_wr(`IDX_BAUD_DIVISOR, 8'h00);
    send(8'h81, 1'b0);
    drain();
    bus_wr(`IDX_TX_CONTROL, 8'h30);
    repeat (3) @(posedge core_clk_in);
    check({30'h0, tx_pin_oe_out, tx_pin_out}, 32'h1);
    ctl = 8'h24;
    per = 16'h0020;
    bus_wr(`IDX_BAUD_DIVISOR, 8'h01);
    send(8'h00, 1'b0);
    while (tx_pin_out !== 1'b0)
      @(posedge core_clk_in);
    repeat (70) @(posedge core_clk_in);
    bus_wr(`IDX_TX_CONTROL, 8'h04);
    void'(exp_rx.pop_back());
    repeat (2) @(posedge core_clk_in);
    check({30'h0, tx_pin_oe_out, tx_pin_out}, 32'h1);
    bus_rd(`IDX_TX_CONTROL, 32'h6, 1'b1);
    bus_rd(`IDX_IRQ_CONTROL, 32'h1, 1'b1);
    // loaded while disabled: nothing leaves until the enable arrives
    d = $urandom;
    bus_wr(`IDX_HOLD_BUFFER, d);
    exp_rx.push_back({2'b11, d});
    repeat (100) @(posedge core_clk_in);
    check({31'h0, tx_pin_out}, 32'h1);
    bus_wr(`IDX_TX_CONTROL, 8'h24);
    drain();
    sleep_in <= 1'b1;
    send($urandom, 1'b0);
    repeat (100) @(posedge core_clk_in);
    check({31'h0, tx_pin_out}, 32'h1);
    sleep_in <= 1'b0;
    drain();
    send($urandom, 1'b0);
    while (tx_pin_out !== 1'b0)
      @(posedge core_clk_in);
    bus_wr(`IDX_RX_CONTROL, 8'h00);
    void'(exp_rx.pop_back());
    bus_rd(`IDX_TX_CONTROL, 32'h26, 1'b1);
    check({31'h0, tx_pin_oe_out}, 32'h0);
    end_of_test();
  end
endmodule // async_serial_transmitter_tb_top
